// ---- opio_pkg.sv ----
/*
 * Shared constants and types of the output and I/O port block: register
 * indexes, field positions, reset values, divider and timing figures.
 * Assumes a classic Wishbone master with 32-bit data and byte addresses.
 */
package opio_pkg;

   // ************************************************************
   // Register indexes (byte address is four times the index)
   // ************************************************************
   localparam logic [7:0] OPIO_IDX_OUT_LATCH = 8'h7C; // Output latch bank
   localparam logic [7:0] OPIO_IDX_GRP0_DATA = 8'h7D; // Low group data
   localparam logic [7:0] OPIO_IDX_TMR_DIR = 8'h7E; // Timer bits and low dir
   localparam logic [7:0] OPIO_IDX_TONE = 8'hF6; // Buzzer tone select
   localparam logic [7:0] OPIO_IDX_GRP1_DATA = 8'hFD; // High group data
   localparam logic [7:0] OPIO_IDX_GRP1_DIR = 8'hFE; // High group direction
   localparam int OPIO_IDX_LSB = 2; // Word index starts at byte bit 2

   // ************************************************************
   // Field positions and reset values
   // ************************************************************
   localparam int OPIO_NIB = 4; // Register data width
   localparam int OPIO_BIT_DIR = 0; // Group direction bit
   localparam int OPIO_BIT_STOPWATCH_RUN = 2; // Stopwatch run bit
   localparam int OPIO_BIT_TONE = 3; // Tone select bit
   localparam int OPIO_BIT_BZ = 0; // Buzzer output bit
   localparam int OPIO_BIT_DIVIDED_CLOCK_OUT = 2; // Clock output bit
   localparam int OPIO_BIT_BZINV = 3; // Inverted buzzer bit
   localparam logic [3:0] OPIO_NIB_RST = 4'h0; // Reset of every nibble
   localparam logic OPIO_BIT_RST = 1'h0; // Reset of single bits

   // ************************************************************
   // Timing: bus clock and oscillator, divider taps
   // ************************************************************
   localparam int OPIO_CLK_HZ = 40_000_000; // Bus clock rate
   localparam int OPIO_OSC_HZ = 32_768; // Nominal oscillator rate
   localparam int OPIO_OSC_HALF_CYC = OPIO_CLK_HZ / (2 * OPIO_OSC_HZ);
   localparam int OPIO_DIV_W = 8; // Divider stages, fosc/1 to fosc/128
   localparam int OPIO_TAP_4K = 3; // fosc/8
   localparam int OPIO_TAP_2K = 4; // fosc/16
   localparam int OPIO_SYNC_W = 3; // Pin synchroniser depth

   // ************************************************************
   // Types
   // ************************************************************
   typedef struct packed {
      logic cyc; // Bus cycle
      logic stb; // Strobe
      logic we; // Write enable
      logic [9:0] adr; // Byte address
      logic [3:0] sel; // Byte selects
      logic [31:0] dat; // Write data
   } opio_wb_req_type;

   typedef enum logic [0:0] {
      OPIO_BUS_IDLE = 1'b0, // Waiting for a request
      OPIO_BUS_ACK = 1'b1 // Answer given this cycle
   } opio_bus_state_type;

endpackage

// ---- opio_divider.sv ----
/*
 * Oscillator model and binary divider. Produces fosc and its seven
 * power-of-two divisions from the bus clock.
 * Assumes the bus clock is far faster than the oscillator rate.
 */
`timescale 1ns/1ps
module opio_divider
   import opio_pkg::*;
#(
   parameter int HALF_CYC = OPIO_OSC_HALF_CYC // Bus cycles per half fosc
) (
   input wire logic clock,
   input wire logic arst_n,
   output logic [OPIO_DIV_W-1:0] taps // Bit n carries fosc/2^n
);

   // ************************************************************
   // Prescaler and divider chain
   // ************************************************************
   localparam int PW = $clog2(HALF_CYC + 1);
   localparam logic [PW-1:0] PRE_LAST = PW'(HALF_CYC - 1);

   logic [PW-1:0] pre_reg; // Half period counter
   logic [OPIO_DIV_W-1:0] div_reg; // Half period count

   // Counts bus cycles, advances divider once per fosc half period
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         pre_reg <= '0;
         div_reg <= '0;
      end else if (pre_reg == PRE_LAST) begin
         pre_reg <= '0;
         div_reg <= div_reg + 1'b1;
      end else begin
         pre_reg <= pre_reg + 1'b1;
      end
   end

   assign taps = div_reg;

endmodule // opio_divider

// ---- opio_top.sv ----
/*
 * Output port and two bidirectional port groups with Wishbone registers,
 * buzzer and divided clock generation.
 * Assumes a classic Wishbone master and pads that resolve each pin from
 * its output and enable; pin inputs are asynchronous.
 */
`timescale 1ns/1ps

// How it works
// - Per output bit push-pull or open-drain driver
// - DC output drives stored bit, reads back
// - Reset clears all four output bits
// - Only bits 0, 2, 3 may be special
// - Bit zero one gives buzzer, zero low
// - Bit three gives inverted buzzer wave
// - Own control: bit three gates inverted wave
// - Shared control: bit zero gates both waves
// - Inverted buzzer needs bit zero buzzer
// - Tone bit one 2 kHz, zero 4 kHz
// - Tone register low bits read zero
// - Clock output one of eight divisions
// - Bit two one gives clock, zero low
// - Direction zero puts group in high impedance
// - Direction one drives the stored data
// - Pull-down only while reading input group
// - Reset puts both groups in input
// - Low group direction at bit zero
// - Reset clears both group output latches
// - Oscillator nominally 32.768 kHz
// - Data writes land in input mode too
module opio_top
   import opio_pkg::*;
#(
   parameter logic [3:0] OUT_OD = 4'h0, // Open-drain per output bit
   parameter logic [7:0] IO_OD = 8'h00, // Open-drain per I/O bit
   parameter bit SEL_BZ = 1'b0, // Bit zero is buzzer output
   parameter bit SEL_DIVIDED_CLOCK_OUT = 1'b0, // Bit two is clock output
   parameter bit SEL_BZINV = 1'b0, // Bit three is inverted buzzer
   parameter bit BZINV_BY_BIT0 = 1'b0, // Bit zero gates inverted buzzer
   parameter int DIVIDED_CLOCK_OUT_DIV_LOG2 = 0, // Clock output is fosc/2^n, 0..7
   parameter int HALF_CYC = OPIO_OSC_HALF_CYC // Bus cycles per half fosc
) (
   input wire logic clock,
   input wire logic arst_n,
   input wire opio_wb_req_type wb_req,
   output logic wb_ack_o,
   output logic [31:0] wb_dat_o,
   output logic [3:0] out_pin_o,
   output logic [3:0] out_pin_oe,
   input wire logic [7:0] io_pin_i,
   output logic [7:0] io_pin_o,
   output logic [7:0] io_pin_oe,
   output logic [1:0] io_pulldown_o
);

   // ************************************************************
   // Build-time checks and effective options
   // ************************************************************
   localparam bit BZINV_ON = SEL_BZINV && SEL_BZ;
   generate
      if (SEL_BZINV && !SEL_BZ) begin : g_bad_cfg
         $error("Inverted buzzer needs bit zero as buzzer");
      end
      if (DIVIDED_CLOCK_OUT_DIV_LOG2 < 0 || DIVIDED_CLOCK_OUT_DIV_LOG2 >= OPIO_DIV_W) begin : g_bad_div
         $error("Clock output division out of range");
      end
   endgenerate

   // ************************************************************
   // Registers
   // ************************************************************
   logic [3:0] out_latch_reg; // Output latch bank
   logic [3:0] grp0_data_reg; // Low group latch
   logic [3:0] grp1_data_reg; // High group latch
   logic dir_low_reg; // Low group direction
   logic dir_high_reg; // High group direction
   logic stopwatch_run_reg; // Stopwatch run bit
   logic tone_reg; // Buzzer tone select
   opio_bus_state_type bus_reg; // Bus answer state
   logic wb_ack_reg; // Acknowledge
   logic [31:0] wb_dat_reg; // Read data
   logic [3:0] out_o_reg; // Output pin levels
   logic [3:0] out_oe_reg; // Output pin enables
   logic [7:0] io_o_reg; // I/O pin levels
   logic [7:0] io_oe_reg; // I/O pin enables
   logic [1:0] pd_reg; // Pull-down enables
   logic [7:0] s1_reg; // Synchroniser stage one
   logic [7:0] s2_reg; // Synchroniser stage two
   logic [7:0] s3_reg; // Synchroniser stage three
   logic [7:0] io_in_reg; // Accepted pin levels
   logic bz_gate_reg; // Buzzer gate
   logic bzinv_gate_reg; // Inverted buzzer gate
   logic divided_clock_out_gate_reg; // Clock output gate

   // ************************************************************
   // Divider and wave selection
   // ************************************************************
   logic [OPIO_DIV_W-1:0] taps; // fosc divisions
   logic bz_wave; // Selected buzzer tone
   logic divided_clock_out_wave; // Selected clock output

   opio_divider #(.HALF_CYC(HALF_CYC)) u_div (
      .clock(clock),
      .arst_n(arst_n),
      .taps(taps)
   );

   // Tone one picks the slower tap
   assign bz_wave = tone_reg ? taps[OPIO_TAP_2K] : taps[OPIO_TAP_4K];
   assign divided_clock_out_wave = taps[DIVIDED_CLOCK_OUT_DIV_LOG2];

   // ************************************************************
   // Bus decode helpers
   // ************************************************************
   logic req; // Live request awaiting answer
   logic wr; // Write taken this cycle
   logic [7:0] idx; // Register index

   assign req = wb_req.cyc && wb_req.stb && (bus_reg == OPIO_BUS_IDLE);
   assign wr = req && wb_req.we && wb_req.sel[0];
   assign idx = wb_req.adr[OPIO_IDX_LSB +: 8];

   // Selects one nibble of the read data
   function automatic logic [3:0] rd_nib(input logic [7:0] i);
      unique case (i)
         OPIO_IDX_OUT_LATCH: rd_nib = out_latch_reg;
         OPIO_IDX_GRP0_DATA: rd_nib = io_in_reg[3:0];
         OPIO_IDX_GRP1_DATA: rd_nib = io_in_reg[7:4];
         OPIO_IDX_TMR_DIR: rd_nib = {1'b0, stopwatch_run_reg, 1'b0, dir_low_reg};
         OPIO_IDX_GRP1_DIR: rd_nib = {3'h0, dir_high_reg};
         OPIO_IDX_TONE: rd_nib = {tone_reg, 3'h0};
         default: rd_nib = OPIO_NIB_RST; // Unmapped reads zero
      endcase
   endfunction

   // Drives a pin: open-drain only pulls high
   function automatic logic [1:0] drive(input logic od, input logic en, input logic v);
      drive = od ? {1'b1, en & v} : {v, en}; // Returns {level, enable}
   endfunction

   // ************************************************************
   // Wishbone slave: answers one cycle after the request
   // ************************************************************
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         bus_reg <= OPIO_BUS_IDLE;
         wb_ack_reg <= 1'b0;
         wb_dat_reg <= '0;
      end else begin
         unique case (bus_reg)
            OPIO_BUS_IDLE: begin
               if (req) begin
                  bus_reg <= OPIO_BUS_ACK;
                  wb_ack_reg <= 1'b1;
                  wb_dat_reg <= {28'h0000000, rd_nib(idx)};
               end
            end
            OPIO_BUS_ACK: begin
               bus_reg <= OPIO_BUS_IDLE; // Ack lasts one cycle
               wb_ack_reg <= 1'b0;
            end
         endcase
      end
   end

   // ************************************************************
   // Register writes
   // ************************************************************
   // Output latch bank
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         out_latch_reg <= OPIO_NIB_RST;
      end else if (wr && idx == OPIO_IDX_OUT_LATCH) begin
         out_latch_reg <= wb_req.dat[OPIO_NIB-1:0];
      end
   end

   // Group latches, written in either direction
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         grp0_data_reg <= OPIO_NIB_RST;
         grp1_data_reg <= OPIO_NIB_RST;
      end else begin
         if (wr && idx == OPIO_IDX_GRP0_DATA) begin
            grp0_data_reg <= wb_req.dat[OPIO_NIB-1:0];
         end
         if (wr && idx == OPIO_IDX_GRP1_DATA) begin
            grp1_data_reg <= wb_req.dat[OPIO_NIB-1:0];
         end
      end
   end

   // Direction bits and stopwatch run bit
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         dir_low_reg <= OPIO_BIT_RST;
         dir_high_reg <= OPIO_BIT_RST;
         stopwatch_run_reg <= OPIO_BIT_RST;
      end else begin
         if (wr && idx == OPIO_IDX_TMR_DIR) begin
            dir_low_reg <= wb_req.dat[OPIO_BIT_DIR];
            stopwatch_run_reg <= wb_req.dat[OPIO_BIT_STOPWATCH_RUN];
         end
         if (wr && idx == OPIO_IDX_GRP1_DIR) begin
            dir_high_reg <= wb_req.dat[OPIO_BIT_DIR];
         end
      end
   end

   // Tone select
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         tone_reg <= OPIO_BIT_RST;
      end else if (wr && idx == OPIO_IDX_TONE) begin
         tone_reg <= wb_req.dat[OPIO_BIT_TONE];
      end
   end

   // ************************************************************
   // Special output gates, changed only while the buzzer or clock wave is low, so the inverted buzzer gate changes while its own wave is high
   // ************************************************************
   logic bzinv_en; // Inverted buzzer control bit

   assign bzinv_en = BZINV_BY_BIT0 ? out_latch_reg[OPIO_BIT_BZ]
                                   : out_latch_reg[OPIO_BIT_BZINV];

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         bz_gate_reg <= 1'b0;
         bzinv_gate_reg <= 1'b0;
         divided_clock_out_gate_reg <= 1'b0;
      end else begin
         if (!bz_wave) begin
            bz_gate_reg <= out_latch_reg[OPIO_BIT_BZ];
            bzinv_gate_reg <= bzinv_en;
         end
         if (!divided_clock_out_wave) begin
            divided_clock_out_gate_reg <= out_latch_reg[OPIO_BIT_DIVIDED_CLOCK_OUT];
         end
      end
   end

   // ************************************************************
   // Output port pins
   // ************************************************************
   logic [3:0] out_val; // Level wanted on each output pin

   always_comb begin
      out_val = out_latch_reg;
      if (SEL_BZ) begin
         out_val[OPIO_BIT_BZ] = bz_gate_reg & bz_wave;
      end
      if (SEL_DIVIDED_CLOCK_OUT) begin
         out_val[OPIO_BIT_DIVIDED_CLOCK_OUT] = divided_clock_out_gate_reg & divided_clock_out_wave;
      end
      if (BZINV_ON) begin
         out_val[OPIO_BIT_BZINV] = bzinv_gate_reg & ~bz_wave;
      end
   end

   // Registered pin drive per output bit
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         out_o_reg <= '0;
         out_oe_reg <= '0;
      end else begin
         for (int i = 0; i < OPIO_NIB; i++) begin
            {out_o_reg[i], out_oe_reg[i]} <= drive(OUT_OD[i], 1'b1, out_val[i]);
         end
      end
   end

   // ************************************************************
   // Bidirectional groups
   // ************************************************************
   logic [7:0] io_lat; // Both group latches
   logic [7:0] io_dir; // Direction per pin

   assign io_lat = {grp1_data_reg, grp0_data_reg};
   assign io_dir = {{4{dir_high_reg}}, {4{dir_low_reg}}};

   // Registered pin drive per I/O bit
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         io_o_reg <= '0;
         io_oe_reg <= '0;
      end else begin
         for (int i = 0; i < 2 * OPIO_NIB; i++) begin
            {io_o_reg[i], io_oe_reg[i]} <= drive(IO_OD[i], io_dir[i], io_lat[i]);
         end
      end
   end

   // Pull-down while a data read of an input group is pending
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         pd_reg <= '0;
      end else begin
         pd_reg[0] <= req && !wb_req.we && idx == OPIO_IDX_GRP0_DATA && !dir_low_reg;
         pd_reg[1] <= req && !wb_req.we && idx == OPIO_IDX_GRP1_DATA && !dir_high_reg;
      end
   end

   // Three-stage synchroniser, change taken when stages two and three agree
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         s1_reg <= '0;
         s2_reg <= '0;
         s3_reg <= '0;
         io_in_reg <= '0;
      end else begin
         s1_reg <= io_pin_i;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         for (int i = 0; i < 2 * OPIO_NIB; i++) begin
            if (s2_reg[i] == s3_reg[i]) begin
               io_in_reg[i] <= s3_reg[i];
            end
         end
      end
   end

   // ************************************************************
   // Outputs
   // ************************************************************
   assign wb_ack_o = wb_ack_reg;
   assign wb_dat_o = wb_dat_reg;
   assign out_pin_o = out_o_reg;
   assign out_pin_oe = out_oe_reg;
   assign io_pin_o = io_o_reg;
   assign io_pin_oe = io_oe_reg;
   assign io_pulldown_o = pd_reg;

   // ************************************************************
   // Assertions
   // ************************************************************
   default clocking cb @(posedge clock); endclocking
   default disable iff (!arst_n);

   a_ack_one_cycle: assert property (wb_ack_reg |=> !wb_ack_reg)
      else $error("Ack held more than one cycle");
   a_latch_write: assert property (wr && idx == OPIO_IDX_OUT_LATCH
      |=> out_latch_reg == $past(wb_req.dat[3:0]))
      else $error("Output latch missed a write");
   a_dc_bit_one: assert property (##1 !OUT_OD[1] |-> ##1 out_o_reg[1] == $past(out_latch_reg[1]))
      else $error("Bit one not a plain DC output");
   a_bz_off_low: assert property (SEL_BZ && !out_latch_reg[0] && !bz_wave |=> out_val[0] == 1'b0)
      else $error("Buzzer pin not low when off");
   a_bzinv_inverse: assert property (BZINV_ON && bz_gate_reg && bzinv_gate_reg
      |-> out_val[3] == !out_val[0])
      else $error("Inverted buzzer not inverse");
   a_divided_clock_out_off_low: assert property (SEL_DIVIDED_CLOCK_OUT && !out_latch_reg[2] && !divided_clock_out_wave
      |=> out_val[2] == 1'b0)
      else $error("Clock output not low when off");
   a_tone_read: assert property (req && !wb_req.we && idx == OPIO_IDX_TONE
      |=> wb_dat_reg[2:0] == 3'h0 && wb_dat_reg[3] == $past(tone_reg))
      else $error("Tone register read wrong");
   a_input_hiz: assert property (!dir_low_reg [*2] |-> io_oe_reg[3:0] == 4'h0)
      else $error("Input group driving");
   a_output_drive: assert property (dir_high_reg && IO_OD[7:4] == 4'h0
      |=> io_oe_reg[7:4] == 4'hF && io_o_reg[7:4] == $past(grp1_data_reg))
      else $error("Output group not driving latch");
   a_pd_only_read: assert property (pd_reg[0] |-> wb_ack_reg && !dir_low_reg)
      else $error("Pull-down outside a read");

   c_bz_on: cover property (SEL_BZ && bz_gate_reg && bz_wave);
   c_divided_clock_out_on: cover property (SEL_DIVIDED_CLOCK_OUT && divided_clock_out_gate_reg && divided_clock_out_wave);
   c_dir_out: cover property (dir_low_reg && dir_high_reg);
   c_pd_read: cover property (pd_reg[1]);

endmodule // opio_top

// ---- opio_load.sv ----
/*
 * Loads on the bidirectional pins: resolves each pin level.
 * Assumes the bench drives ext_drv and ext_en in place of outside parts.
 */
`timescale 1ns/1ps
module opio_load (
   input wire logic clock,
   input wire logic [7:0] io_pin_o,
   input wire logic [7:0] io_pin_oe,
   input wire logic [1:0] io_pulldown_o,
   input wire logic [7:0] ext_drv,
   input wire logic [7:0] ext_en,
   output logic [7:0] io_pin_i
);
   // ************************************************************
   // Pin resolution
   // ************************************************************
   logic [7:0] float_reg = 8'h55; // Wandering level of a floating pin

   // Floating pins change every cycle so no stale level is read
   always @(posedge clock) begin
      float_reg <= ~float_reg;
   end

   // Device drive first, then outside drive, then pull-down
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         if (io_pin_oe[i]) begin
            io_pin_i[i] = io_pin_o[i];
         end else if (ext_en[i]) begin
            io_pin_i[i] = ext_drv[i];
         end else if (io_pulldown_o[i/4]) begin
            io_pin_i[i] = 1'b0;
         end else begin
            io_pin_i[i] = float_reg[i];
         end
      end
   end
endmodule // opio_load

// ---- tb_output_and_io_port_block.sv ----
/*
 * Self-checking bench of the port block over Wishbone.
 * Assumes opio_top with a short oscillator half period.
 */
`timescale 1ns/1ps
module tb_output_and_io_port_block;
   import opio_pkg::*;
   localparam int HC = 2; // Bus cycles per half oscillator period
   logic clock, arst_n, wb_ack_o;
   opio_wb_req_type wb_req;
   logic [31:0] wb_dat_o, rd;
   logic [3:0] out_pin_o, out_pin_oe;
   logic [7:0] io_pin_i, io_pin_o, io_pin_oe, ext_drv, ext_en;
   logic [1:0] io_pulldown_o, pd;
   logic [3:0] out2_o, out2_oe; // Second build: open-drain, shared control
   logic [7:0] io2_oe; // Second build I/O enables
   int err_count, n_compared, p;
   localparam logic [31:0] RST_IDX = 32'h7C7EF6FE; // Indexes read back after reset

   opio_top #(.SEL_BZ(1'b1), .SEL_DIVIDED_CLOCK_OUT(1'b1), .SEL_BZINV(1'b1), .DIVIDED_CLOCK_OUT_DIV_LOG2(1),
      .HALF_CYC(HC)) dut (.clock(clock), .arst_n(arst_n), .wb_req(wb_req),
      .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .out_pin_o(out_pin_o),
      .out_pin_oe(out_pin_oe), .io_pin_i(io_pin_i), .io_pin_o(io_pin_o),
      .io_pin_oe(io_pin_oe), .io_pulldown_o(io_pulldown_o));
   opio_load load (.clock(clock), .io_pin_o(io_pin_o), .io_pin_oe(io_pin_oe),
      .io_pulldown_o(io_pulldown_o), .ext_drv(ext_drv), .ext_en(ext_en),
      .io_pin_i(io_pin_i));

   // Open-drain bit one and low group, inverted buzzer gated by bit zero
   opio_top #(.OUT_OD(4'h2), .IO_OD(8'h0F), .SEL_BZ(1'b1), .SEL_BZINV(1'b1),
      .BZINV_BY_BIT0(1'b1), .HALF_CYC(HC)) dut2 (.clock(clock), .arst_n(arst_n),
      .wb_req(wb_req), .wb_ack_o(), .wb_dat_o(), .out_pin_o(out2_o),
      .out_pin_oe(out2_oe), .io_pin_i(io_pin_i), .io_pin_o(), .io_pin_oe(io2_oe),
      .io_pulldown_o());

   // ************************************************************
   // Clock and helpers
   // ************************************************************
   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end

   // Verdict and end of run
   task automatic test_done();
      $display("compared %0d, errors %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   // Value comparison
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // One classic Wishbone cycle; read data and pull-down taken at ack
   task automatic wb(input logic w, input logic [7:0] idx, input logic [3:0] d);
      int n;
      n = 0;
      @(posedge clock);
      wb_req <= '{1'b1, 1'b1, w, {idx, 2'b00}, 4'hF, {28'h0, d}};
      do begin
         @(posedge clock);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      if (n >= 20) begin
         err_count++;
         test_done();
      end
      rd = wb_dat_o;
      pd = io_pulldown_o;
      wb_req <= '0;
   endtask

   // Cycles between two rising edges of an output pin
   task automatic period(input int b, output int c);
      c = 0;
      for (int k = 0; k < 2; k++) begin
         c = 0;
         do begin @(negedge clock); c++; end while (out_pin_o[b] !== 1'b0 && c < 300);
         do begin @(negedge clock); c++; end while (out_pin_o[b] !== 1'b1 && c < 300);
      end
      if (c >= 300) begin
         err_count++;
         test_done();
      end
   endtask

   // ************************************************************
   // Main sequence
   // ************************************************************
   initial begin
      arst_n = 1'b0;
      wb_req = '0;
      ext_en = 8'h00;
      ext_drv = 8'h00;
      repeat (4) @(posedge clock);
      arst_n <= 1'b1;
      @(posedge clock);
      @(negedge clock);
      chk({out_pin_oe, out_pin_o, io_pin_oe}, 32'h0F000);
      chk({out2_oe, out2_o}, 8'hD2);
      for (int i = 0; i < 4; i++) begin
         wb(1'b0, RST_IDX[8*i +: 8], 4'h0);
         chk(rd, 32'h0);
      end
      wb(1'b1, 8'h7C, 4'h2);
      @(negedge clock);
      chk(out_pin_o, 4'h2);
      chk({out2_oe[1], out2_o[1]}, 2'b11);
      wb(1'b0, 8'h7C, 4'h0);
      chk(rd, 32'h2);
      wb(1'b1, 8'h7D, 4'hA);
      @(negedge clock);
      chk(io_pin_oe, 8'h00);
      wb(1'b1, 8'h7E, 4'h1);
      @(negedge clock);
      chk({io_pin_oe[3:0], io_pin_o[3:0]}, 8'hFA);
      chk(io2_oe[3:0], 4'hA);
      wb(1'b0, 8'h7E, 4'h0);
      chk(rd, 32'h1);
      ext_en <= 8'hF0;
      ext_drv <= 8'h50;
      repeat (8) @(posedge clock);
      wb(1'b0, 8'h7D, 4'h0);
      chk(rd, 32'hA);
      chk(pd, 2'b00);
      wb(1'b0, 8'hFD, 4'h0);
      chk(rd, 32'h5);
      chk(pd, 2'b10);
      wb(1'b1, 8'hFE, 4'h1);
      @(negedge clock);
      chk({io_pin_oe[7:4], io_pin_o[7:4]}, 8'hF0);
      repeat (8) @(posedge clock);
      wb(1'b0, 8'hFD, 4'h0);
      chk(rd, 32'h0);
      chk(pd, 2'b00);
      wb(1'b0, 8'hFE, 4'h0);
      chk(rd, 32'h1);
      wb(1'b1, 8'h10, 4'hF);
      wb(1'b0, 8'h10, 4'h0);
      chk(rd, 32'h0);
      wb(1'b1, 8'hF6, 4'hF);
      wb(1'b0, 8'hF6, 4'h0);
      chk(rd, 32'h8);
      wb(1'b1, 8'h7C, 4'hF);
      period(0, p);
      chk(p, 2 * HC * 16);
      period(3, p);
      chk(p, 2 * HC * 16);
      period(2, p);
      chk(p, 2 * HC * 2);
      repeat (16) begin
         @(negedge clock);
         chk(out_pin_o[3], !out_pin_o[0]);
      end
      wb(1'b1, 8'hF6, 4'h0);
      period(0, p);
      chk(p, 2 * HC * 8);
      wb(1'b1, 8'h7C, 4'h1);
      repeat (80) @(negedge clock);
      chk(out_pin_o[3:1], 3'h0);
      repeat (16) begin
         @(negedge clock);
         chk(out2_o[3], !out2_o[0]);
      end
      wb(1'b1, 8'h7C, 4'h0);
      repeat (80) @(negedge clock);
      chk(out_pin_o, 4'h0);
      chk({out2_o[3], out2_o[0]}, 2'b00);
      test_done();
   end

   // Whole-run limit
   initial begin
      #1000000;
      err_count++;
      test_done();
   end
endmodule // tb_output_and_io_port_block
